// file: hdl/supply_monitor_consts.vh
// constants and bit layout of the supply monitor control register
// Overview of operation
// - When enabled, both supplies are compared against one of four selectable trip levels each and a low one is flagged.
// - Control bit 0 enables the monitor when written one and disables it when written zero.
// - Bit 7 reads the live digital-supply comparator state, one meaning above its trip level.
// - Bit 6 reads the live analog-supply comparator state, one meaning above its trip level.
// - The low-supply flag in bit 5 is set whenever either comparator reports a low supply while the monitor is enabled.
// - Once both comparators are high and stay high a hold-off counter runs and clears the flag on expiry.
// - Software may write the flag, but a clear has no effect while the monitor is enabled and either comparator is low.
// - Bits 4 and 3 select the digital trip level: 00 4.63 V, 01 3.08 V, 10 2.93 V, 11 2.63 V.
// - Bits 2 and 1 select the analog trip level with the same encoding.
// - The flag raises the core interrupt only while the core enables the monitor interrupt.
// - Comparator outputs are filtered so brief glitches neither set the flag nor interrupt.
`ifndef SUPPLY_MONITOR_CONSTS_VH
`define SUPPLY_MONITOR_CONSTS_VH

`define SMC_ADDR 8'hdf
`define SMC_RESET 8'hde
`define SMC_DIG_OK_BIT 7
`define SMC_ANA_OK_BIT 6
`define SMC_FLAG_BIT 5
`define SMC_DIG_TRIP_HI 4
`define SMC_DIG_TRIP_LO 3
`define SMC_ANA_TRIP_HI 2
`define SMC_ANA_TRIP_LO 1
`define SMC_ENABLE_BIT 0

// trip levels in millivolts per select code
`define TRIP_MV_CODE0 4630
`define TRIP_MV_CODE1 3080
`define TRIP_MV_CODE2 2930
`define TRIP_MV_CODE3 2630

// timing
`define CLK_MHZ 250
`define HOLDOFF_MS 250
`define HOLDOFF_CYCLES (`HOLDOFF_MS * 1000 * `CLK_MHZ)
`define GLITCH_CYCLES 16

`endif

// file: hdl/supply_glitch_filter.v
// glitch filter: output follows the input only after it has been stable for a set time
`timescale 1ns/10ps
`default_nettype none
module supply_glitch_filter #(
    parameter integer STABLE_CYCLES = 16,
    parameter integer CNT_W = 8
) (
    input wire clk_sys,
    input wire rst,
    input wire raw_in,
    output reg filt_r
);
    reg [CNT_W-1:0] cnt_r;

    // count cycles in which the input differs from the output; any agreement restarts
    always @(posedge clk_sys) begin
        if (rst) begin
            filt_r <= 1'b1;
            cnt_r <= {CNT_W{1'b0}};
        end else if (raw_in == filt_r) begin
            cnt_r <= {CNT_W{1'b0}}; // glitch ended before acceptance
        end else if (cnt_r == STABLE_CYCLES[CNT_W-1:0] - 1'b1) begin
            filt_r <= raw_in;
            cnt_r <= {CNT_W{1'b0}};
        end else begin
            cnt_r <= cnt_r + 1'b1;
        end
    end
endmodule // supply_glitch_filter
`default_nettype wire

// file: hdl/supply_monitor_control.v
// supply monitor control logic with its control and status register
`timescale 1ns/10ps
`default_nettype none
`include "supply_monitor_consts.vh"
module supply_monitor_control #(
    parameter [31:0] HOLDOFF_CYCLES = `HOLDOFF_CYCLES,
    parameter integer GLITCH_CYCLES = `GLITCH_CYCLES
) (
    input wire clk_sys,
    input wire rst,
    input wire [7:0] sfr_addr,
    input wire sfr_wr,
    input wire sfr_rd,
    input wire [7:0] sfr_wdata,
    output reg [7:0] sfr_rdata,
    input wire digital_cmp_raw,
    input wire analog_cmp_raw,
    input wire psm_int_enable,
    output wire monitor_enable,
    output wire [1:0] digital_trip_sel,
    output wire [1:0] analog_trip_sel,
    output wire low_supply_irq
);
    // reset image of the register; every stored field's reset value is taken from it
    localparam [7:0] RESET_IMAGE = `SMC_RESET;

    // last count of the hold-off; the counter starts at zero
    localparam [31:0] HOLDOFF_LAST = HOLDOFF_CYCLES - 32'h1;

    // flag sequencer states
    localparam [1:0] ST_CLEAR = 2'h0; // flag low, supplies good
    localparam [1:0] ST_LOW = 2'h1; // a supply is low, flag pinned high
    localparam [1:0] ST_HOLD = 2'h2; // supplies good again, hold-off running
    localparam [1:0] ST_SPARE = 2'h3; // unused code, recovers at once

    // configuration fields written by software
    reg monitor_enable_r;
    reg [1:0] digital_trip_r;
    reg [1:0] analog_trip_r;

    // flag sequencer registers and their next values
    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg low_supply_flag_r;
    reg low_supply_flag_nxt;
    reg [31:0] holdoff_cnt_r;
    reg [31:0] holdoff_cnt_nxt;

    // register image as software sees it
    reg [7:0] reg_view;

    // filtered comparators and decoded accesses
    wire digital_filt;
    wire analog_filt;
    wire digital_supply_ok;
    wire analog_supply_ok;
    wire any_low;
    wire hit_wr;
    wire hit_rd;
    wire holdoff_done;

    // two-bit field of a register byte whose low bit sits at lo
    function [1:0] field2;
        input [7:0] data;
        input integer lo;
        begin
            field2 = {data[lo + 1], data[lo]};
        end
    endfunction

    // a supply counts as low only while the monitor runs
    function supply_low;
        input filt_ok;
        input enabled;
        begin
            supply_low = enabled & ~filt_ok;
        end
    endfunction

    // glitch filters in front of both comparators
    supply_glitch_filter #(.STABLE_CYCLES(GLITCH_CYCLES), .CNT_W(8)) u_dig_filt (
        .clk_sys(clk_sys),
        .rst(rst),
        .raw_in(digital_cmp_raw),
        .filt_r(digital_filt)
    );
    supply_glitch_filter #(.STABLE_CYCLES(GLITCH_CYCLES), .CNT_W(8)) u_ana_filt (
        .clk_sys(clk_sys),
        .rst(rst),
        .raw_in(analog_cmp_raw),
        .filt_r(analog_filt)
    );

    // a disabled monitor reports both supplies good to the flag logic
    assign digital_supply_ok = ~supply_low(digital_filt, monitor_enable_r);
    assign analog_supply_ok = ~supply_low(analog_filt, monitor_enable_r);
    assign any_low = ~digital_supply_ok | ~analog_supply_ok;

    // address decode of the single control register
    assign hit_wr = sfr_wr && (sfr_addr == `SMC_ADDR);
    assign hit_rd = sfr_rd && (sfr_addr == `SMC_ADDR);

    // end of the hold-off span
    assign holdoff_done = (holdoff_cnt_r == HOLDOFF_LAST);

    // drive the analog comparators
    assign monitor_enable = monitor_enable_r;
    assign digital_trip_sel = digital_trip_r;
    assign analog_trip_sel = analog_trip_r;

    // configuration fields written by software; bits 7 and 6 are not stored
    always @(posedge clk_sys) begin
        if (rst) begin
            monitor_enable_r <= RESET_IMAGE[`SMC_ENABLE_BIT];
            digital_trip_r <= field2(RESET_IMAGE, `SMC_DIG_TRIP_LO);
            analog_trip_r <= field2(RESET_IMAGE, `SMC_ANA_TRIP_LO);
        end else if (hit_wr) begin
            monitor_enable_r <= sfr_wdata[`SMC_ENABLE_BIT];
            digital_trip_r <= field2(sfr_wdata, `SMC_DIG_TRIP_LO);
            analog_trip_r <= field2(sfr_wdata, `SMC_ANA_TRIP_LO);
        end
    end

    // next state of the flag sequencer
    // a low supply outranks a software write, so a clear can never win while low;
    // a software write of one restarts the hold-off and a write of zero ends it, so a flag set by
    // software while supplies are good clears itself after the hold-off
    always @* begin
        state_nxt = state_r;
        low_supply_flag_nxt = low_supply_flag_r;
        holdoff_cnt_nxt = holdoff_cnt_r;
        if (any_low) begin
            state_nxt = ST_LOW;
            low_supply_flag_nxt = 1'b1;
            holdoff_cnt_nxt = 32'h0;
        end else if (hit_wr) begin
            low_supply_flag_nxt = sfr_wdata[`SMC_FLAG_BIT];
            holdoff_cnt_nxt = 32'h0;
            if (sfr_wdata[`SMC_FLAG_BIT]) begin
                state_nxt = ST_HOLD;
            end else begin
                state_nxt = ST_CLEAR;
            end
        end else begin
            case (state_r)
                ST_CLEAR: begin
                    // nothing pending; the counter rests at zero
                    low_supply_flag_nxt = 1'b0;
                    holdoff_cnt_nxt = 32'h0;
                end
                ST_LOW, ST_HOLD: begin
                    // both supplies good: count out the hold-off
                    if (holdoff_done) begin
                        state_nxt = ST_CLEAR;
                        low_supply_flag_nxt = 1'b0;
                        holdoff_cnt_nxt = 32'h0;
                    end else begin
                        state_nxt = ST_HOLD;
                        holdoff_cnt_nxt = holdoff_cnt_r + 32'h1;
                    end
                end
                ST_SPARE: begin
                    // never entered; restart the hold-off if the flag stands
                    state_nxt = low_supply_flag_r ? ST_HOLD : ST_CLEAR;
                    holdoff_cnt_nxt = 32'h0;
                end
                default: begin
                    state_nxt = ST_CLEAR;
                    low_supply_flag_nxt = 1'b0;
                    holdoff_cnt_nxt = 32'h0;
                end
            endcase
        end
    end

    // flag sequencer registers
    always @(posedge clk_sys) begin
        if (rst) begin
            state_r <= ST_CLEAR;
            low_supply_flag_r <= RESET_IMAGE[`SMC_FLAG_BIT];
            holdoff_cnt_r <= 32'h0;
        end else begin
            state_r <= state_nxt;
            low_supply_flag_r <= low_supply_flag_nxt;
            holdoff_cnt_r <= holdoff_cnt_nxt;
        end
    end

    // register image with live comparator bits, placed field by field
    always @* begin
        reg_view = 8'h00;
        reg_view[`SMC_DIG_OK_BIT] = digital_filt;
        reg_view[`SMC_ANA_OK_BIT] = analog_filt;
        reg_view[`SMC_FLAG_BIT] = low_supply_flag_r;
        reg_view[`SMC_DIG_TRIP_HI] = digital_trip_r[1];
        reg_view[`SMC_DIG_TRIP_LO] = digital_trip_r[0];
        reg_view[`SMC_ANA_TRIP_HI] = analog_trip_r[1];
        reg_view[`SMC_ANA_TRIP_LO] = analog_trip_r[0];
        reg_view[`SMC_ENABLE_BIT] = monitor_enable_r;
    end

    // read data captured on a read strobe, zero for other addresses
    // the comparator bits show the filtered state even while the monitor is off
    always @(posedge clk_sys) begin
        if (rst) begin
            sfr_rdata <= 8'h00;
        end else if (hit_rd) begin
            sfr_rdata <= reg_view;
        end else if (sfr_rd) begin
            sfr_rdata <= 8'h00;
        end
    end

    // interrupt request gated by the core's enable
    // the request is a level: it stands as long as the flag and the enable do
    assign low_supply_irq = low_supply_flag_r & psm_int_enable;
endmodule // supply_monitor_control
`default_nettype wire

// file: testbench/supply_monitor_properties.sv
// port checks for the supply monitor control logic
`timescale 1ns/10ps
`default_nettype none
module supply_monitor_properties #(
    parameter int GLITCH_CYCLES = 16
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic digital_cmp_raw,
    input wire logic analog_cmp_raw,
    input wire logic psm_int_enable,
    input wire logic monitor_enable,
    input wire logic [1:0] digital_trip_sel,
    input wire logic [1:0] analog_trip_sel,
    input wire logic low_supply_irq
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // a write that hits the control register
    wire hit = sfr_wr && sfr_addr == 8'hdf;
    // consecutive cycles with the monitor on and the digital comparator low
    logic [15:0] low_cnt;
    always @(posedge clk_sys) begin
        if (rst || !(monitor_enable && !digital_cmp_raw)) low_cnt <= 16'h0;
        else if (low_cnt != 16'hffff) low_cnt <= low_cnt + 16'h1;
    end
    AST_EN_WR: assert property (hit |=> monitor_enable == $past(sfr_wdata[0]))
        else $error("enable not taken");
    AST_DTRIP: assert property (hit |=> digital_trip_sel == $past(sfr_wdata[4:3]))
        else $error("digital trip not taken");
    AST_ATRIP: assert property (hit |=> analog_trip_sel == $past(sfr_wdata[2:1]))
        else $error("analog trip not taken");
    AST_HOLD: assert property (!hit |=> $stable({monitor_enable, digital_trip_sel, analog_trip_sel}))
        else $error("config moved without write");
    AST_IRQ: assert property (low_supply_irq |-> psm_int_enable)
        else $error("irq while masked");
    AST_RD0: assert property (sfr_rd && sfr_addr != 8'hdf |=> sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_SET: assert property (low_cnt >= GLITCH_CYCLES + 1 && psm_int_enable |-> low_supply_irq)
        else $error("low supply not flagged");
    AST_KEEP: assert property (low_cnt >= GLITCH_CYCLES + 1 && hit && !sfr_wdata[5] |=> low_supply_irq || !psm_int_enable)
        else $error("flag cleared while low");
endmodule // supply_monitor_properties
bind supply_monitor_control supply_monitor_properties #(.GLITCH_CYCLES(GLITCH_CYCLES)) chk_i (
    .clk_sys(clk_sys), .rst(rst),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .digital_cmp_raw(digital_cmp_raw), .analog_cmp_raw(analog_cmp_raw),
    .psm_int_enable(psm_int_enable), .monitor_enable(monitor_enable),
    .digital_trip_sel(digital_trip_sel), .analog_trip_sel(analog_trip_sel),
    .low_supply_irq(low_supply_irq));
`default_nettype wire

// file: testbench/supply_partner.sv
// behavioural supply comparators and core interrupt enable
`timescale 1ns/10ps
`default_nettype none
module supply_partner (
    output logic digital_cmp_raw,
    output logic analog_cmp_raw,
    output logic psm_int_enable
);
    initial psm_int_enable = 1'b1;
    initial {digital_cmp_raw, analog_cmp_raw} = 2'b11;
    // pull the chosen supplies below trip, called after a falling edge
    task automatic drive(input logic [1:0] lo);
        {digital_cmp_raw, analog_cmp_raw} = ~lo;
    endtask
    // core side interrupt enable, called after a falling edge
    task automatic set_ien(input logic en);
        psm_int_enable = en;
    endtask
endmodule // supply_partner
`default_nettype wire

// file: testbench/supply_monitor_control_bench.sv
// self-checking bench for the supply monitor control logic
`timescale 1ns/10ps
`default_nettype none
module supply_monitor_control_bench;
    logic clk_sys = 1'b0, rst = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0, rd_d = 1'b0;
    logic [7:0] sfr_addr = 8'hdf, sfr_wdata = 8'h00, seed = 8'h10, r;
    logic [15:0] exp_q[$], e;
    wire [7:0] sfr_rdata;
    wire dig, ana, ien, mon_en, irq;
    wire [1:0] dtrip, atrip;
    int n_fail = 0, samples_checked = 0;
    always #2 clk_sys = ~clk_sys;
    supply_monitor_control #(.HOLDOFF_CYCLES(32'd20), .GLITCH_CYCLES(4)) uut (
        .clk_sys(clk_sys), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .digital_cmp_raw(dig),
        .analog_cmp_raw(ana), .psm_int_enable(ien), .monitor_enable(mon_en),
        .digital_trip_sel(dtrip), .analog_trip_sel(atrip), .low_supply_irq(irq));
    supply_partner far (.digital_cmp_raw(dig), .analog_cmp_raw(ana), .psm_int_enable(ien));
    // xorshift source for data and addresses
    function automatic logic [7:0] xs();
        seed ^= seed << 3;
        seed ^= seed >> 5;
        seed ^= seed << 1;
        return seed;
    endfunction
    // one strobe cycle, launched after a falling edge, then one idle cycle
    task automatic acc(input logic wr, input logic [7:0] a, d);
        {sfr_wr, sfr_rd, sfr_addr, sfr_wdata} = {wr, !wr, a, d};
        @(negedge clk_sys);
        {sfr_wr, sfr_rd} = 2'b00;
        @(negedge clk_sys);
    endtask
    // read with expected data and expected register image for the pins
    task automatic rd(input logic [7:0] a, x, img);
        exp_q.push_back({img, x});
        acc(1'b0, a, 8'h00);
    endtask
    task automatic chk_rd(input logic [7:0] got, want);
        samples_checked++;
        if (got !== want) begin
            n_fail++;
            $display("[FAIL] %0t rdata got %h exp %h", $time, got, want);
        end
    endtask
    task automatic chk_pins(input logic [5:0] got, want);
        samples_checked++;
        if (got !== want) begin
            n_fail++;
            $display("[FAIL] %0t pins got %h exp %h", $time, got, want);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d failures %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // compare each read answer with the oldest expectation
    always @(posedge clk_sys) begin
        if (rd_d) begin
            e = exp_q.pop_front();
            chk_rd(sfr_rdata, e[7:0]);
            chk_pins({irq, mon_en, dtrip, atrip}, {e[13] & ien, e[8], e[12:11], e[10:9]});
        end
        rd_d <= sfr_rd;
    end
    initial begin
        #40000;
        n_fail++;
        tally_and_finish();
    end
    initial begin
        repeat (16) @(negedge clk_sys);
        rst = 1'b0;
        rd(8'hdf, 8'hde, 8'hde);
        for (int c = 0; c < 4; c++) begin
            r = xs();
            acc(1'b1, 8'hdf, {r[7:6], 1'b0, c[1:0], c[1:0], 1'b1});
            rd(8'hdf, {3'b110, c[1:0], c[1:0], 1'b1}, {3'b110, c[1:0], c[1:0], 1'b1});
            rd({r[7:1], 1'b0}, 8'h00, {3'b110, c[1:0], c[1:0], 1'b1});
        end
        far.drive(2'b10);
        repeat (8) @(negedge clk_sys);
        rd(8'hdf, 8'h7f, 8'h7f);
        acc(1'b1, 8'hdf, 8'hdf);
        far.set_ien(1'b0);
        rd(8'hdf, 8'h7f, 8'h7f);
        far.set_ien(1'b1);
        far.drive(2'b00);
        repeat (15) @(negedge clk_sys);
        far.drive(2'b01);
        repeat (6) @(negedge clk_sys);
        far.drive(2'b00);
        repeat (20) @(negedge clk_sys);
        rd(8'hdf, 8'hff, 8'hff);
        repeat (10) @(negedge clk_sys);
        rd(8'hdf, 8'hdf, 8'hdf);
        far.drive(2'b10);
        repeat (xs() % 3 + 1) @(negedge clk_sys);
        far.drive(2'b00);
        repeat (8) @(negedge clk_sys);
        rd(8'hdf, 8'hdf, 8'hdf);
        acc(1'b1, 8'hdf, 8'h3f);
        rd(8'hdf, 8'hff, 8'hff);
        tally_and_finish();
    end
endmodule // supply_monitor_control_bench
`default_nettype wire
